// ---- rtl/dme_params.svh ----
// register offsets, field positions, reset values and fixed-point constants
`ifndef DME_PARAMS_SVH
`define DME_PARAMS_SVH
// ****************************************
// register map
// ****************************************
`define DME_ADDR_CTRL 4'h0
`define DME_ADDR_CAL 4'h1
`define DME_ADDR_ATTEN 4'h2
`define DME_ADDR_SNR 4'h3
`define DME_ADDR_SQI 4'h4
`define DME_ADDR_STATUS 4'h5
`define DME_CTRL_ACCURATE_BIT 0
// ****************************************
// reset values
// ****************************************
`define DME_CAL_RST 16'h0000
`define DME_ATTEN_RST 16'h0419
`define DME_SNR_RST 16'h0080
`define DME_SQI_RST 8'h80
// ****************************************
// arithmetic constants and counts
// ****************************************
`define DME_CORDIC_LAST 4'hd
`define DME_DIV_LAST 3'h7
`define DME_DB_PER_OCT 14'sh0303
`define DME_FAST_LN 14'sh0163
`define DME_ACC_LN 14'sh0076
`define DME_INV_PI2 13'h19f1
`define DME_CORDIC_GAIN 16'h4dba
`define DME_ONE_KM 16'h0100
`define DME_ONE_KM_LOG 14'sh0800
`define DME_QUARTER_TURN 16'h4000
`endif

// ---- rtl/dme_pkg.sv ----
// types shared by the moment estimator modules
package dme_pkg;
	// ****************************************
	// sequencer states, gray along the path
	// ****************************************
	typedef enum logic [2:0] {
		DME_IDLE = 3'b000,
		DME_VECTOR = 3'b001,
		DME_LOGS = 3'b011,
		DME_DIVIDE = 3'b010,
		DME_FINISH = 3'b110
	} dme_state_t;

	typedef struct packed {
		logic busy;
		logic done;
		logic [3:0] iter;
		logic signed [35:0] x;
		logic signed [35:0] y;
		logic [15:0] z;
	} dme_cordic_t;

	typedef struct packed {
		dme_state_t state;
		logic inReady;
		logic accurate;
		logic signed [15:0] calRefl;
		logic [15:0] atten;
		logic signed [15:0] snrThresh;
		logic [7:0] sqiThresh;
		logic [15:0] binCount;
		logic [31:0] rdData;
		logic [31:0] total;
		logic [31:0] noise;
		logic [31:0] r0;
		logic signed [15:0] clutter;
		logic [15:0] rangeKm;
		logic binAccurate;
		logic [15:0] phase;
		logic [31:0] mag1;
		logic [31:0] mag2;
		logic signed [15:0] snrDb;
		logic signed [15:0] rangeDb;
		logic signed [15:0] attenDb;
		logic snrPos;
		logic [15:0] variance;
		logic [32:0] divRem;
		logic [7:0] divQ;
		logic [2:0] divStep;
		logic resultValid;
		logic signed [15:0] reflDb;
		logic reflPass;
		logic signed [7:0] velCode;
		logic [7:0] widthCode;
		logic [7:0] sqiCode;
		logic sqiPass;
		logic binInvalid;
	} dme_core_t;
endpackage

// ---- rtl/dme_log2.sv ----
// combinational base-two logarithm, 5 integer and 8 fraction bits
`timescale 1ns/1ps
module dme_log2 (
	input wire logic [31:0] value, // unsigned operand, zero reads as zero
	output logic [12:0] logVal // log2 in Q5.8
);
	logic [4:0] pos;
	logic [31:0] norm;

	// leading one gives the integer part, the bits below it a linear fraction
	always_comb begin
		pos = 5'h0;
		for (int i = 0; i < 32; i++) begin
			if (value[i]) begin
				pos = 5'(i);
			end
		end
		norm = value << (5'h1f - pos);
		logVal = {pos, norm[30:23]};
	end
endmodule // dme_log2

// ---- rtl/dme_cordic.sv ----
// iterative vectoring cordic: phase and scaled magnitude of a complex lag
`timescale 1ns/1ps
`include "dme_params.svh"
module dme_cordic (
	input wire logic clk, // processing clock
	input wire logic sys_rst, // synchronous reset
	input wire logic clkEn, // freezes state when low
	input wire logic start, // one-cycle start, operands sampled here
	input wire logic signed [31:0] inRe, // real part
	input wire logic signed [31:0] inIm, // imaginary part
	output logic done, // one-cycle pulse with result
	output logic [35:0] magnitude, // magnitude times cordic gain
	output logic [15:0] phase // angle, 16'h8000 is pi
);
	dme_pkg::dme_cordic_t st;
	dme_pkg::dme_cordic_t next_st;
	logic signed [35:0] xs;
	logic signed [35:0] ys;
	logic [15:0] step;

	// arctangent of 2^-i scaled so that pi is 2^15
	always_comb begin
		case (st.iter)
			4'h0: step = 16'h2000;
			4'h1: step = 16'h12e4;
			4'h2: step = 16'h09fb;
			4'h3: step = 16'h0511;
			4'h4: step = 16'h028b;
			4'h5: step = 16'h0146;
			4'h6: step = 16'h00a3;
			4'h7: step = 16'h0051;
			4'h8: step = 16'h0029;
			4'h9: step = 16'h0014;
			4'ha: step = 16'h000a;
			4'hb: step = 16'h0005;
			4'hc: step = 16'h0003;
			default: step = 16'h0001;
		endcase
	end

	// pre-rotation into the right half plane, then micro-rotations toward y = 0
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		xs = st.x >>> st.iter;
		ys = st.y >>> st.iter;
		if (start && !st.busy) begin
			next_st.busy = 1'b1;
			next_st.iter = 4'h0;
			if (!inRe[31]) begin
				next_st.x = 36'(inRe);
				next_st.y = 36'(inIm);
				next_st.z = 16'h0000;
			end else if (!inIm[31]) begin
				next_st.x = 36'(inIm);
				next_st.y = -36'(inRe);
				next_st.z = `DME_QUARTER_TURN;
			end else begin
				next_st.x = -36'(inIm);
				next_st.y = 36'(inRe);
				next_st.z = -`DME_QUARTER_TURN;
			end
		end else if (st.busy) begin
			if (!st.y[35]) begin
				next_st.x = st.x + ys;
				next_st.y = st.y - xs;
				next_st.z = st.z + step;
			end else begin
				next_st.x = st.x - ys;
				next_st.y = st.y + xs;
				next_st.z = st.z - step;
			end
			if (st.iter == `DME_CORDIC_LAST) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end else begin
				next_st.iter = st.iter + 4'h1;
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else if (clkEn) begin
			st <= next_st;
		end
	end

	assign done = st.done;
	assign magnitude = st.x;
	assign phase = st.z;
endmodule // dme_cordic

// ---- rtl/dme_moment_estimator.sv ----
// per-bin reflectivity, velocity, width and quality index from lag sums
// Behaviour
// - reflectivity dB sums SNR dB, calibration, 20log range, attenuation times range, clutter term.
// - reflectivity passes only when SNR term exceeds the programmed threshold.
// - calibration refers to 1 km; range term is zero there.
// - attenuation coefficient is configuration state defaulting to 0.016 dB per km.
// - velocity phase is the lag-one argument within minus pi to pi.
// - velocities past the limit wrap into the Nyquist interval.
// - velocity output is phase over pi, spanning minus one to one.
// - fast two-lag or accurate three-lag width chosen by a setup bit.
// - fast variance is 2 ln of lag-zero power over lag-one magnitude.
// - width is square root of variance over pi, Nyquist normalised.
// - accurate variance is two thirds ln of lag-one over lag-two magnitude.
// - quality index is lag-one magnitude over lag-zero power, 0 to 1.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "dme_params.svh"
module dme_moment_estimator (
	input wire logic clk, // processing clock
	input wire logic sys_rst, // synchronous reset
	input wire logic clkEn, // freezes all state when low
	input wire logic binValid, // bin operands valid
	input wire logic [31:0] lag0Total, // unfiltered lag-zero power
	input wire logic [31:0] noisePower, // noise estimate
	input wire logic [31:0] lag0Filt, // filtered lag-zero power
	input wire logic signed [31:0] lag1Re, // lag-one real
	input wire logic signed [31:0] lag1Im, // lag-one imaginary
	input wire logic signed [31:0] lag2Re, // lag-two real
	input wire logic signed [31:0] lag2Im, // lag-two imaginary
	input wire logic signed [15:0] clutterCorr, // clutter_correction_term, Q8.8 dB
	input wire logic [15:0] rangeKm, // range, Q8.8 km
	input wire logic [3:0] regAddr, // register index
	input wire logic [31:0] regWrData, // write data
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	output logic inReady, // bin accepted when high with binValid
	output logic [31:0] regRdData, // read data, cycle after strobe
	output logic resultValid, // one-cycle result strobe
	output logic signed [15:0] reflDb, // reflectivity, Q8.8 dB
	output logic reflPass, // reflectivity SNR test passed
	output logic signed [7:0] velCode, // normalised velocity code
	output logic [7:0] widthCode, // normalised width code
	output logic [7:0] sqiCode, // signal_quality_index, Q0.8
	output logic sqiPass, // quality index above threshold
	output logic binInvalid // zero divisor in this bin
);
	// ****************************************
	// state and arithmetic helpers
	// ****************************************
	dme_pkg::dme_core_t st;
	dme_pkg::dme_core_t next_st;
	logic [31:0] logIn [6];
	logic [12:0] logOut [6];
	logic signed [31:0] corRe [2];
	logic signed [31:0] corIm [2];
	logic corDone [2];
	logic [35:0] corMag [2];
	logic [15:0] corPhase [2];
	logic signed [13:0] dSnr;
	logic signed [13:0] dRange;
	logic signed [13:0] dVar;
	logic signed [27:0] pSnr;
	logic signed [27:0] pRange;
	logic signed [27:0] pVar;
	logic [31:0] pAtten;
	logic signed [18:0] sumRefl;
	logic [28:0] pWidth;
	logic [11:0] rootW;
	logic [32:0] remShift;
	logic invalid;

	// undo the cordic gain and clip to 32 bits
	function automatic logic [31:0] scaleMag(input logic [35:0] m);
		logic [51:0] p;
		p = m * `DME_CORDIC_GAIN;
		if (|p[51:47]) begin
			return 32'hffff_ffff;
		end
		return p[46:15];
	endfunction

	// bit-serial integer square root, unrolled
	function automatic logic [11:0] isqrt(input logic [23:0] v);
		logic [11:0] r;
		logic [11:0] c;
		r = 12'h000;
		for (int b = 11; b >= 0; b--) begin
			c = r | (12'h001 << b);
			if (24'(c) * 24'(c) <= v) begin
				r = c;
			end
		end
		return r;
	endfunction

	// ****************************************
	// arithmetic units
	// ****************************************
	assign logIn[0] = (st.total > st.noise) ? st.total - st.noise : 32'h0000_0000;
	assign logIn[1] = st.noise;
	assign logIn[2] = st.r0;
	assign logIn[3] = st.mag1;
	assign logIn[4] = st.mag2;
	assign logIn[5] = {16'h0000, (st.rangeKm == 16'h0000) ? 16'h0001 : st.rangeKm};
	assign corRe[0] = lag1Re;
	assign corIm[0] = lag1Im;
	assign corRe[1] = lag2Re;
	assign corIm[1] = lag2Im;

	// one log unit per operand, one cordic per lag
	generate
		for (genvar g = 0; g < 6; g++) begin : gLog
			dme_log2 uLog (
				.value(logIn[g]),
				.logVal(logOut[g])
			);
		end
		for (genvar g = 0; g < 2; g++) begin : gCordic
			dme_cordic uCordic (
				.clk(clk),
				.sys_rst(sys_rst),
				.clkEn(clkEn),
				.start(binValid && st.inReady),
				.inRe(corRe[g]),
				.inIm(corIm[g]),
				.done(corDone[g]),
				.magnitude(corMag[g]),
				.phase(corPhase[g])
			);
		end
	endgenerate

	// ****************************************
	// register port and moment sequencer
	// ****************************************
	always_comb begin
		next_st = st;
		next_st.resultValid = 1'b0;
		dSnr = 14'(logOut[0]) - 14'(logOut[1]);
		dRange = 14'(logOut[5]) - `DME_ONE_KM_LOG;
		dVar = st.binAccurate ? 14'(logOut[3]) - 14'(logOut[4]) : 14'(logOut[2]) - 14'(logOut[3]);
		pSnr = 28'(dSnr) * 28'(`DME_DB_PER_OCT);
		pRange = 28'(dRange) * 28'(`DME_DB_PER_OCT);
		pVar = 28'(dVar) * 28'(st.binAccurate ? `DME_ACC_LN : `DME_FAST_LN);
		pAtten = st.atten * st.rangeKm;
		sumRefl = 19'(st.snrDb) + 19'(st.calRefl) + 19'(st.rangeDb) + 19'(st.attenDb) + 19'(st.clutter);
		pWidth = st.variance * `DME_INV_PI2;
		rootW = isqrt({3'b000, pWidth[28:8]});
		remShift = {st.divRem[31:0], 1'b0};
		invalid = (st.r0 == 32'h0) || (st.noise == 32'h0) || (st.mag1 == 32'h0)
			|| (st.binAccurate && st.mag2 == 32'h0);
		// register writes; software setup steers the sequencer and result scaling
		if (regWr) begin
			case (regAddr)
				`DME_ADDR_CTRL: next_st.accurate = regWrData[`DME_CTRL_ACCURATE_BIT];
				`DME_ADDR_CAL: next_st.calRefl = regWrData[15:0];
				`DME_ADDR_ATTEN: next_st.atten = regWrData[15:0];
				`DME_ADDR_SNR: next_st.snrThresh = regWrData[15:0];
				`DME_ADDR_SQI: next_st.sqiThresh = regWrData[7:0];
				default: ;
			endcase
		end
		// read data for the next cycle only, unmapped reads zero
		next_st.rdData = 32'h0000_0000;
		if (regRd) begin
			case (regAddr)
				`DME_ADDR_CTRL: next_st.rdData = {31'h0, st.accurate};
				`DME_ADDR_CAL: next_st.rdData = {16'h0000, st.calRefl};
				`DME_ADDR_ATTEN: next_st.rdData = {16'h0000, st.atten};
				`DME_ADDR_SNR: next_st.rdData = {16'h0000, st.snrThresh};
				`DME_ADDR_SQI: next_st.rdData = {24'h0, st.sqiThresh};
				`DME_ADDR_STATUS: next_st.rdData = {st.binCount, 15'h0, st.state != dme_pkg::DME_IDLE};
				default: ;
			endcase
		end
		case (st.state)
			dme_pkg::DME_IDLE: begin
				if (binValid) begin
					next_st.total = lag0Total;
					next_st.noise = noisePower;
					next_st.r0 = lag0Filt;
					next_st.clutter = clutterCorr;
					next_st.rangeKm = rangeKm;
					next_st.binAccurate = st.accurate;
					next_st.inReady = 1'b0;
					next_st.state = dme_pkg::DME_VECTOR;
				end
			end
			dme_pkg::DME_VECTOR: begin
				if (corDone[0]) begin
					next_st.phase = corPhase[0];
					next_st.mag1 = scaleMag(corMag[0]);
					next_st.mag2 = scaleMag(corMag[1]);
					next_st.state = dme_pkg::DME_LOGS;
				end
			end
			dme_pkg::DME_LOGS: begin
				next_st.snrDb = pSnr[23:8];
				next_st.snrPos = st.total > st.noise;
				next_st.rangeDb = 16'(pRange[23:8] <<< 1);
				next_st.attenDb = pAtten[31:16];
				next_st.variance = pVar[27] ? 16'h0000 : pVar[23:8];
				next_st.divRem = {1'b0, st.mag1};
				next_st.divQ = 8'h00;
				next_st.divStep = 3'h0;
				next_st.state = dme_pkg::DME_DIVIDE;
			end
			dme_pkg::DME_DIVIDE: begin
				// restoring division of lag-one magnitude by lag-zero power
				if (remShift >= {1'b0, st.r0}) begin
					next_st.divRem = remShift - {1'b0, st.r0};
					next_st.divQ = {st.divQ[6:0], 1'b1};
				end else begin
					next_st.divRem = remShift;
					next_st.divQ = {st.divQ[6:0], 1'b0};
				end
				next_st.divStep = st.divStep + 3'h1;
				if (st.divStep == `DME_DIV_LAST) begin
					next_st.state = dme_pkg::DME_FINISH;
				end
			end
			dme_pkg::DME_FINISH: begin
				if (sumRefl > 19'sh07fff) begin
					next_st.reflDb = 16'sh7fff;
				end else if (sumRefl < -19'sh08000) begin
					next_st.reflDb = -16'sh8000;
				end else begin
					next_st.reflDb = sumRefl[15:0];
				end
				next_st.reflPass = st.snrPos && (st.noise != 32'h0) && (st.snrDb > st.snrThresh);
				next_st.velCode = st.phase[15:8];
				if (invalid) begin
					next_st.sqiCode = 8'h00;
					next_st.widthCode = 8'h00;
				end else begin
					next_st.sqiCode = (st.mag1 >= st.r0) ? 8'hff : st.divQ;
					next_st.widthCode = (|rootW[11:8]) ? 8'hff : rootW[7:0];
				end
				next_st.sqiPass = !invalid && (((st.mag1 >= st.r0) ? 8'hff : st.divQ) > st.sqiThresh);
				next_st.binInvalid = invalid;
				next_st.resultValid = 1'b1;
				next_st.binCount = st.binCount + 16'h0001;
				next_st.inReady = 1'b1;
				next_st.state = dme_pkg::DME_IDLE;
			end
			default: begin
				next_st.inReady = 1'b1;
				next_st.state = dme_pkg::DME_IDLE;
			end
		endcase
	end

	// state register, reset values of the setup registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
			st.inReady <= 1'b1;
			st.calRefl <= `DME_CAL_RST;
			st.atten <= `DME_ATTEN_RST;
			st.snrThresh <= `DME_SNR_RST;
			st.sqiThresh <= `DME_SQI_RST;
		end else if (clkEn) begin
			st <= next_st;
		end
	end

	assign inReady = st.inReady;
	assign regRdData = st.rdData;
	assign resultValid = st.resultValid;
	assign reflDb = st.reflDb;
	assign reflPass = st.reflPass;
	assign velCode = st.velCode;
	assign widthCode = st.widthCode;
	assign sqiCode = st.sqiCode;
	assign sqiPass = st.sqiPass;
	assign binInvalid = st.binInvalid;

	// ****************************************
	// assertions and covers
	// ****************************************
	logic signed [15:0] astSum;
	logic astFin;
	assign astSum = st.snrDb + st.calRefl + st.rangeDb + st.attenDb + st.clutter;
	assign astFin = (st.state == dme_pkg::DME_FINISH) && clkEn;

	AST_REFL_SUM: assert property (@(posedge clk) disable iff (sys_rst)
		astFin && !sumRefl[18] && sumRefl < 19'sh04000 && sumRefl > -19'sh04000 |=> reflDb == $past(astSum))
		else $error("reflectivity is not the five-term sum");
	AST_REFL_PASS: assert property (@(posedge clk) disable iff (sys_rst)
		astFin && !st.snrPos |=> resultValid && !reflPass)
		else $error("reflectivity passed without positive SNR");
	AST_RANGE_REF: assert property (@(posedge clk) disable iff (sys_rst)
		st.state == dme_pkg::DME_LOGS && clkEn && st.rangeKm == `DME_ONE_KM |=> st.rangeDb == 16'sh0000)
		else $error("range term not zero at reference range");
	AST_ATTEN_DEFAULT: assert property (@(posedge clk) sys_rst |=> st.atten == `DME_ATTEN_RST)
		else $error("attenuation default lost at reset");
	AST_VEL_PHASE: assert property (@(posedge clk) disable iff (sys_rst)
		astFin |=> velCode == $signed(8'($past(st.phase) >> 8)))
		else $error("velocity code does not follow phase");
	AST_CAPTURE_MODE: assert property (@(posedge clk) disable iff (sys_rst)
		st.state == dme_pkg::DME_IDLE && binValid && clkEn |=> st.binAccurate == $past(st.accurate)
		##0 st.state == dme_pkg::DME_VECTOR ##[1:40] st.state == dme_pkg::DME_LOGS)
		else $error("width mode not captured or vectoring stalled");
	AST_FAST_FLOOR: assert property (@(posedge clk) disable iff (sys_rst)
		st.state == dme_pkg::DME_LOGS && clkEn && !st.binAccurate && logOut[2] <= logOut[3] |=> st.variance == 16'h0)
		else $error("fast variance nonzero with unit ratio");
	AST_WIDTH_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
		astFin && st.variance == 16'h0 |=> widthCode == 8'h00)
		else $error("width nonzero for zero variance");
	AST_ACC_FLOOR: assert property (@(posedge clk) disable iff (sys_rst)
		st.state == dme_pkg::DME_LOGS && clkEn && st.binAccurate && logOut[3] <= logOut[4] |=> st.variance == 16'h0)
		else $error("accurate variance nonzero with unit ratio");
	AST_SQI_FULL: assert property (@(posedge clk) disable iff (sys_rst)
		astFin && st.mag1 >= st.r0 && !invalid |=> sqiCode == 8'hff)
		else $error("quality index not saturated at one");
	AST_INVALID: assert property (@(posedge clk) disable iff (sys_rst)
		astFin && (st.r0 == 32'h0 || st.mag1 == 32'h0) |=> resultValid && binInvalid && sqiCode == 8'h00)
		else $error("zero divisor not flagged");
	COV_PASS: cover property (@(posedge clk) resultValid && reflPass && sqiPass);
	COV_INVALID: cover property (@(posedge clk) resultValid && binInvalid);
	COV_ACCURATE: cover property (@(posedge clk) resultValid && st.binAccurate && !binInvalid);
	COV_WIDTH_SAT: cover property (@(posedge clk) resultValid && widthCode == 8'hff);
	COV_REFL_FAIL: cover property (@(posedge clk) resultValid && !reflPass && !binInvalid);

	// ****************************************
	// threshold, saturation and divisor checks
	// ****************************************
	AST_SNR_BELOW: assert property (@(posedge clk) disable iff (sys_rst)
		astFin && st.snrDb <= st.snrThresh |=> resultValid && !reflPass)
		else $error("reflectivity passed below the SNR threshold");
	AST_ZERO_NOISE: assert property (@(posedge clk) disable iff (sys_rst)
		astFin && st.noise == 32'h0 |=> binInvalid && !reflPass && !sqiPass)
		else $error("zero noise not flagged");
	AST_WIDTH_SAT: assert property (@(posedge clk) disable iff (sys_rst)
		astFin && !invalid && rootW > 12'h0ff |=> widthCode == 8'hff)
		else $error("width code not saturated");
	AST_LAG2_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
		astFin && st.binAccurate && st.mag2 == 32'h0 |=> binInvalid && widthCode == 8'h00)
		else $error("zero lag-two magnitude not flagged");
endmodule // dme_moment_estimator

// ---- tb/dme_partner.sv ----
// upstream lag source model presenting one averaged bin at a time
`timescale 1ns/1ps
module dme_partner (
	input wire logic clk, // processing clock
	input wire logic send, // load a new bin
	input wire logic [255:0] binIn, // packed bin operands
	input wire logic inReady, // estimator ready
	input wire logic clkEn, // estimator enable
	output logic binValid, // bin presented
	output logic [255:0] binOut // operands, inverted once taken
);
	initial binValid = 1'b0;
	initial binOut = '0;
	// hold the bin until taken, then stop showing the old value
	always @(posedge clk) begin
		if (send) begin
			binOut <= binIn;
			binValid <= 1'b1;
		end else if (binValid && inReady && clkEn) begin
			binOut <= ~binOut;
			binValid <= 1'b0;
		end
	end
endmodule // dme_partner

// ---- tb/dme_moment_estimator_tb.sv ----
// self-checking bench for the moment estimator
`timescale 1ns/1ps
`include "dme_params.svh"
module dme_moment_estimator_tb;
	localparam int LIMIT = 3000;
	localparam logic [31:0] amp = 32'h100000;
	logic clk, sys_rst = 1'b1, clkEn = 1'b1, send = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic [255:0] binIn = '0, bo;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0, regRdData, t0 = 32'h200, nz = 32'h100, cyc = 32'h0;
	logic [15:0] clut = 16'h0, rng = 16'h0100;
	logic [7:0] sqiThr = 8'h80, widthCode, sqiCode;
	logic signed [15:0] reflDb;
	logic signed [7:0] velCode;
	logic binValid, inReady, resultValid, reflPass, sqiPass, binInvalid;
	int n_errors = 0, num_checks = 0;
	int tq [$];
	logic [31:0] tRe [6] = '{amp, 32'h0, -amp, 32'h0, amp, -amp};
	logic [31:0] tIm [6] = '{32'h0, amp, 32'h0, -amp, amp, 32'hffffc000};
	logic signed [7:0] tVel [6] = '{8'sh00, 8'sh40, 8'sh80, 8'shc0, 8'sh20, 8'sh80};

	dme_moment_estimator i_dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .binValid(binValid),
		.lag0Total(bo[255:224]), .noisePower(bo[223:192]), .lag0Filt(bo[191:160]), .lag1Re(bo[159:128]),
		.lag1Im(bo[127:96]), .lag2Re(bo[95:64]), .lag2Im(bo[63:32]), .clutterCorr(bo[31:16]),
		.rangeKm(bo[15:0]), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.inReady(inReady), .regRdData(regRdData), .resultValid(resultValid), .reflDb(reflDb),
		.reflPass(reflPass), .velCode(velCode), .widthCode(widthCode), .sqiCode(sqiCode),
		.sqiPass(sqiPass), .binInvalid(binInvalid));
	dme_partner i_src (.clk(clk), .send(send), .binIn(binIn), .inReady(inReady), .clkEn(clkEn),
		.binValid(binValid), .binOut(bo));

	// clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// cycle count and hang limit
	always @(posedge clk) begin
		cyc <= cyc + 32'h1;
		if (cyc == LIMIT) begin
			n_errors++;
			print_verdict();
		end
	end
	// note the cycle before each accepted bin
	always @(negedge clk) if (binValid && inReady && clkEn && !sys_rst) tq.push_back(cyc);

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol, input string msg);
		num_checks++;
		if ($isunknown(got) || $signed(got - exp) > tol || $signed(exp - got) > tol) begin
			n_errors++;
			$display("mismatch at %0t: %s got %0h want %0h", $time, msg, got, exp);
		end
	endtask
	// register port, entered just after a rising edge
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string msg);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		chk(regRdData, exp, 0, msg);
		@(posedge clk);
	endtask
	// bin stream through the source model
	task automatic put_bin(input logic [31:0] r0, re, im, r2);
		send <= 1'b1;
		binIn <= {t0, nz, r0, re, im, r2, 32'h0, clut, rng};
		@(posedge clk);
		send <= 1'b0;
	endtask
	task automatic wait_take();
		repeat (60) begin
			@(negedge clk);
			if (binValid && inReady) break;
		end
		@(posedge clk);
	endtask
	task automatic res(input logic signed [15:0] eRefl, input int rTol, input logic ePass,
		input logic signed [7:0] eVel, input logic [7:0] eW, input int wTol, input logic [7:0] eSqi,
		input logic eInv);
		int lat;
		logic signed [7:0] dVel;
		lat = -1;
		repeat (80) begin
			@(negedge clk);
			if (resultValid === 1'b1) break;
		end
		if (tq.size() > 0) lat = cyc - tq.pop_front() - 1;
		chk(resultValid, 32'h1, 0, "no result");
		chk(lat, 32'd25, 0, "latency");
		chk(reflDb, eRefl, rTol, "reflectivity");
		chk(reflPass, ePass, 0, "snr pass");
		dVel = velCode - eVel;
		chk(dVel, 32'h0, 1, "velocity");
		chk(widthCode, eW, wTol, "width");
		chk(sqiCode, eSqi, 2, "quality");
		chk(sqiPass, !eInv && eSqi > sqiThr, 0, "quality pass");
		chk(binInvalid, eInv, 0, "invalid");
		@(posedge clk);
	endtask
	task automatic refl_bin(input logic signed [15:0] eRefl, input logic ePass);
		put_bin(32'hf0000, amp, 32'h0, 32'h0);
		res(eRefl, 4, ePass, 8'sh0, 8'h0, 2, 8'hff, 1'b0);
	endtask

	// ****
	// tests
	// ****
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`DME_ADDR_CTRL, 32'h0, "ctrl reset");
		rd(`DME_ADDR_CAL, 32'h0, "cal reset");
		rd(`DME_ADDR_ATTEN, 32'h419, "atten reset");
		rd(`DME_ADDR_SNR, 32'h80, "snr reset");
		rd(`DME_ADDR_SQI, 32'h80, "sqi reset");
		rd(`DME_ADDR_STATUS, 32'h0, "status reset");
		rd(4'h6, 32'h0, "unmapped");
		rd(4'hf, 32'h0, "unmapped");
		wr(`DME_ADDR_CAL, 32'hffff1400);
		rd(`DME_ADDR_CAL, 32'h1400, "cal write");
		wr(`DME_ADDR_STATUS, 32'hffffffff);
		rd(`DME_ADDR_STATUS, 32'h0, "status read only");
		clkEn <= 1'b0;
		wr(`DME_ADDR_CAL, 32'h0100);
		clkEn <= 1'b1;
		rd(`DME_ADDR_CAL, 32'h1400, "write while frozen");
		sqiThr = 8'h73;
		wr(`DME_ADDR_SQI, 32'h73);
		rd(`DME_ADDR_SQI, 32'h73, "sqi write");
		$display("test registers done");
		// phase to code, pairs sent back to back
		for (int i = 0; i < 6; i += 2) begin
			put_bin(32'hf0000, tRe[i], tIm[i], 32'h0);
			wait_take();
			put_bin(32'hf0000, tRe[i + 1], tIm[i + 1], 32'h0);
			res(16'sh1404, 4, 1'b0, tVel[i], 8'h0, 2, 8'hff, 1'b0);
			res(16'sh1404, 4, 1'b0, tVel[i + 1], 8'h0, 2, 8'hff, 1'b0);
		end
		$display("test velocity done");
		put_bin(32'h400000, amp, 32'h0, 32'h0);
		res(16'sh1404, 4, 1'b0, 8'sh0, 8'h88, 8, 8'h40, 1'b0);
		put_bin(32'h40000000, 32'h100, 32'h0, 32'h0);
		res(16'sh1404, 4, 1'b0, 8'sh0, 8'hff, 0, 8'h0, 1'b0);
		put_bin(32'h0, amp, 32'h0, 32'h0);
		res(16'sh1404, 4, 1'b0, 8'sh0, 8'h0, 0, 8'h0, 1'b1);
		wr(`DME_ADDR_CTRL, 32'h1);
		put_bin(32'hf0000, amp, 32'h0, 32'h40000);
		res(16'sh1404, 4, 1'b0, 8'sh0, 8'h4e, 8, 8'hff, 1'b0);
		put_bin(32'hf0000, amp, 32'h0, 32'h0);
		res(16'sh1404, 4, 1'b0, 8'sh0, 8'h0, 0, 8'h0, 1'b1);
		wr(`DME_ADDR_CTRL, 32'h0);
		rd(`DME_ADDR_CTRL, 32'h0, "ctrl write");
		$display("test width done");
		wr(`DME_ADDR_ATTEN, 32'h0);
		clut = 16'hfd00;
		refl_bin(16'sh1100, 1'b0);
		t0 = 32'h900;
		refl_bin(16'sh1a09, 1'b1);
		rng = 16'h0200;
		refl_bin(16'sh200f, 1'b1);
		wr(`DME_ADDR_ATTEN, 32'h8000);
		refl_bin(16'sh210f, 1'b1);
		wr(`DME_ADDR_SNR, 32'h0a00);
		refl_bin(16'sh210f, 1'b0);
		t0 = 32'h100;
		put_bin(32'hf0000, amp, 32'h0, 32'h0);
		res(16'sh0, 70000, 1'b0, 8'sh0, 8'h0, 2, 8'hff, 1'b0);
		nz = 32'h0;
		put_bin(32'hf0000, amp, 32'h0, 32'h0);
		res(16'sh0, 70000, 1'b0, 8'sh0, 8'h0, 0, 8'h0, 1'b1);
		$display("test reflectivity done");
		print_verdict();
	end
endmodule // dme_moment_estimator_tb
